// *** ccu_pin_model.sv ***
// Far-side model: the first timebase counter and the signal source or load on the unit pin.
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_model
  import ccu_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 run,
  input  wire logic                 load_en,
  input  wire logic [CCU_CNT_W-1:0] load_val,
  input  wire logic                 src_lvl,
  input  wire logic                 pin_oe,
  input  wire logic                 pin_out,
  input  wire logic                 tb_clear,
  output logic [CCU_CNT_W-1:0]      tb_count,
  output logic                      tb_write,
  output logic                      pin_in
);
  logic [CCU_CNT_W-1:0] cnt_q;

  // Synchronous timer mode only, so the unit never sees a count that moves between its edges.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (load_en)
      cnt_q <= load_val;
    else if (tb_clear)
      cnt_q <= '0;
    else if (run)
      cnt_q <= cnt_q + 16'h0001;
  end

  // A software load is reported to the unit in the same cycle it lands.
  assign tb_count = cnt_q;
  assign tb_write = load_en;

  // While the unit drives the pin the source lets go and the wire follows the driver.
  assign pin_in = pin_oe ? pin_out : src_lvl;
endmodule
`default_nettype wire

// *** ccu_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a new level once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_sync
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin_async,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The chain; the first stage feeds only the second stage.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted only when the last two stages agree, which filters one-cycle glitches.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      level_q <= 1'b0;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

endmodule
`default_nettype wire

// *** ccu_pkg.sv ***
// Package with register map, field layout, mode codes and reset values of the capture/compare unit.
package ccu_pkg;

  // Bus geometry: each register index is one 32-bit word, byte address is four times the index.
  localparam int unsigned CCU_ADDR_W     = 10;
  localparam int unsigned CCU_IDX_W      = 8;
  localparam int unsigned CCU_DATA_W     = 32;
  localparam int unsigned CCU_BE_W       = 4;
  localparam int unsigned CCU_CNT_W      = 16;
  localparam int unsigned CCU_BYTE_W     = 8;

  // Register indices.
  localparam logic [7:0] CCU_IDX_FLAG    = 8'h0C;
  localparam logic [7:0] CCU_IDX_VAL_LO  = 8'h15;
  localparam logic [7:0] CCU_IDX_VAL_HI  = 8'h16;
  localparam logic [7:0] CCU_IDX_CTRL    = 8'h17;
  localparam logic [7:0] CCU_IDX_ENABLE  = 8'h8C;

  // Control register layout: duty bits 5:4, mode field 3:0, bits 7:6 read as zero.
  localparam int unsigned CCU_CTRL_MODE_LSB = 0;
  localparam int unsigned CCU_CTRL_MODE_W   = 4;
  localparam int unsigned CCU_CTRL_DUTY_LSB = 4;
  localparam int unsigned CCU_CTRL_DUTY_W   = 2;
  localparam logic [7:0]  CCU_CTRL_RESET    = 8'h00;

  // Event flag and event enable both sit at bit 2 of their registers.
  localparam int unsigned CCU_EVENT_BIT     = 2;

  // Mode field encodings.
  localparam logic [3:0] CCU_MODE_OFF      = 4'h0;
  localparam logic [3:0] CCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_MODE_CAP_4TH  = 4'h6;
  localparam logic [3:0] CCU_MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] CCU_MODE_CMP_HIGH = 4'h8;
  localparam logic [3:0] CCU_MODE_CMP_LOW  = 4'h9;
  localparam logic [3:0] CCU_MODE_CMP_SWI  = 4'hA;
  localparam logic [3:0] CCU_MODE_CMP_SEV  = 4'hB;

  // Prescaler terminal counts for the every 4th and every 16th rising edge modes.
  localparam logic [3:0] CCU_PSC_LAST_4    = 4'h3;
  localparam logic [3:0] CCU_PSC_LAST_16   = 4'hF;

  // Reset values of the value register bytes.
  localparam logic [7:0] CCU_VAL_RESET     = 8'h00;

endpackage

// *** ccu_top.sv ***
// Capture/compare unit with an Avalon-MM register slave, pin logic and special event trigger.
//
// Behaviour
// R1 - Sixteen-bit value register as low and high byte plus control register, all R/W.
// R2 - First timebase serves capture and compare; second timebase only serves PWM.
// R3 - Capture copies the whole sixteen-bit first timebase count into the value register.
// R4 - Capture event: falling edge, rising edge, every fourth or sixteenth rising edge.
// R5 - Each capture sets the event flag at bit two; software clears it.
// R6 - A new capture overwrites an unread earlier value.
// R7 - With the pin driven, a port latch change may cause a capture.
// R8 - Software runs the first timebase in timer or synchronized counter mode.
// R9 - Mode change may flag falsely; software masks and clears around it.
// R10 - Prescaler counter is cleared whenever the unit is off or not capturing.
// R11 - Switching prescale settings directly keeps the counter and may flag.
// R12 - Software turns the unit off before loading a new prescale mode.
// R13 - Compare match drives the pin high, low, or leaves it unchanged.
// R14 - Every compare match sets the event flag in every compare sub-mode.
// R15 - Software makes the pin an output for compare, input for capture.
// R16 - Writing zero to the control register forces the compare latch low.
// R17 - Software interrupt sub-mode leaves the pin alone and only flags.
// R18 - Special event match clears the first timebase, making a period register.
// R19 - Special event also pulses an A/D start-conversion request.
// R20 - Mode value 1011 selects the special event trigger.
// R21 - Timebase clearing by the trigger never sets its overflow flag.
// R22 - A coinciding software timebase write wins over the trigger.
// R23 - Mode zero means off: no captures, compare actions or flags.
`timescale 1ns/1ps
`default_nettype none
module ccu_top
  import ccu_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [CCU_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [CCU_DATA_W-1:0] avs_writedata,
  input  wire logic [CCU_BE_W-1:0]   avs_byteenable,
  output logic [CCU_DATA_W-1:0]      avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [CCU_CNT_W-1:0]  tb_count,
  input  wire logic                  tb_write,
  output logic                       tb_clear,
  output logic                       adc_start,
  input  wire logic                  port_dir_in,
  input  wire logic                  port_data,
  input  wire logic                  pin_in,
  output logic                       pin_out,
  output logic                       pin_oe
);

  // True for the four capture encodings.
  function automatic logic ccu_is_capture(input logic [3:0] mode);
    ccu_is_capture = (mode == CCU_MODE_CAP_FALL) || (mode == CCU_MODE_CAP_RISE) ||
                     (mode == CCU_MODE_CAP_4TH) || (mode == CCU_MODE_CAP_16TH);
  endfunction

  // True for the four compare encodings.
  function automatic logic ccu_is_compare(input logic [3:0] mode);
    ccu_is_compare = (mode == CCU_MODE_CMP_HIGH) || (mode == CCU_MODE_CMP_LOW) ||
                     (mode == CCU_MODE_CMP_SWI) || (mode == CCU_MODE_CMP_SEV);
  endfunction

  logic [7:0]           val_lo_q;
  logic [7:0]           val_hi_q;
  logic [7:0]           ctrl_q;
  logic                 flag_q;
  logic                 enable_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [3:0]           psc_q;
  logic                 prev_q;
  logic                 match_prev_q;
  logic                 cmp_latch_q;
  logic                 tb_clear_q;
  logic                 adc_start_q;
  logic                 pin_out_q;
  logic                 pin_oe_q;
  logic                 pin_level;
  logic [3:0]           mode;
  logic [CCU_IDX_W-1:0] idx;
  logic                 wr_acc;
  logic                 wr_lane0;
  logic                 sample;
  logic                 rise;
  logic                 fall;
  logic                 cap_evt;
  logic                 match;
  logic                 cmp_evt;
  logic [31:0]          rdata_d;

  // Synchronised pin level for capture.
  ccu_pin_sync u_pin_sync
  (
    .mclk      (mclk),
    .rst       (rst),
    .pin_async (pin_in),
    .level_q   (pin_level)
  );

  // Decoded request terms; writes take effect only on the edge that ends the accept cycle.
  assign mode     = ctrl_q[CCU_CTRL_MODE_LSB +: CCU_CTRL_MODE_W];
  assign idx      = avs_address[CCU_ADDR_W-1:2];
  assign wr_acc   = avs_write && !wait_q;
  assign wr_lane0 = wr_acc && avs_byteenable[0];

  // Bus handshake: one wait cycle, then one accept cycle, so every access takes two edges.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read || avs_write) && wait_q);
  end

  // Read multiplexer; unmapped indices answer zero.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (idx)
      CCU_IDX_VAL_LO: rdata_d[7:0] = val_lo_q;
      CCU_IDX_VAL_HI: rdata_d[7:0] = val_hi_q;
      CCU_IDX_CTRL:   rdata_d[7:0] = ctrl_q;
      CCU_IDX_FLAG:   rdata_d[CCU_EVENT_BIT] = flag_q;
      CCU_IDX_ENABLE: rdata_d[CCU_EVENT_BIT] = enable_q;
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the wait cycle and stands through the accept cycle.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
      rdata_q <= rdata_d; // [R1]
  end

  // Control register; duty bits are stored only, since PWM is not built here.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_q <= CCU_CTRL_RESET;
    else if (wr_lane0 && idx == CCU_IDX_CTRL)
      ctrl_q <= {2'b00, avs_writedata[5:0]}; // [R1] [R12]
  end

  // Event enable is kept for software only; the block has no interrupt line.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      enable_q <= 1'b0;
    else if (wr_lane0 && idx == CCU_IDX_ENABLE)
      enable_q <= avs_writedata[CCU_EVENT_BIT]; // [R9]
  end

  // Capture source: while the unit drives the pin, its own output is looked at, so a port
  // latch change reaches the edge detector without a round trip through the pad.
  assign sample = pin_oe_q ? pin_out_q : pin_level; // [R7]
  assign rise   = sample && !prev_q;
  assign fall   = !sample && prev_q;

  // The edge history is not reset on mode changes, which is why a mode switch can flag.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= sample; // [R9]
  end

  // Capture event selection by mode field.
  always_comb
  begin
    case (mode)
      CCU_MODE_CAP_FALL: cap_evt = fall; // [R4]
      CCU_MODE_CAP_RISE: cap_evt = rise; // [R4]
      CCU_MODE_CAP_4TH:  cap_evt = rise && (psc_q[1:0] == CCU_PSC_LAST_4[1:0]); // [R4] [R11]
      CCU_MODE_CAP_16TH: cap_evt = rise && (psc_q == CCU_PSC_LAST_16); // [R4]
      default:           cap_evt = 1'b0; // [R23]
    endcase
  end

  // Prescaler: counts rising edges in capture modes, cleared otherwise, kept across
  // prescale changes so the first capture after a switch can come early. A control write
  // that leaves capture clears it on the same edge, so no count is held while the unit is off.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      psc_q <= 4'h0;
    else if (!ccu_is_capture(mode))
      psc_q <= 4'h0; // [R10]
    else if (wr_lane0 && idx == CCU_IDX_CTRL &&
             !ccu_is_capture(avs_writedata[CCU_CTRL_MODE_LSB +: CCU_CTRL_MODE_W]))
      psc_q <= 4'h0; // [R10]
    else if (rise)
      psc_q <= psc_q + 4'h1; // [R11]
  end

  // Compare acts once per arrival at equality, not on every cycle the count rests there.
  assign match   = ccu_is_compare(mode) && (tb_count == {val_hi_q, val_lo_q}); // [R2] [R8]
  assign cmp_evt = match && !match_prev_q; // [R13]

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      match_prev_q <= 1'b0;
    else
      match_prev_q <= match;
  end

  // Value bytes: software writes, and a capture overwrites whatever is held.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      val_lo_q <= CCU_VAL_RESET;
      val_hi_q <= CCU_VAL_RESET;
    end
    else if (cap_evt)
    begin
      val_lo_q <= tb_count[7:0]; // [R3] [R6]
      val_hi_q <= tb_count[15:8]; // [R3]
    end
    else
    begin
      if (wr_lane0 && idx == CCU_IDX_VAL_LO)
        val_lo_q <= avs_writedata[7:0]; // [R1]
      if (wr_lane0 && idx == CCU_IDX_VAL_HI)
        val_hi_q <= avs_writedata[7:0]; // [R1]
    end
  end

  // Event flag: a writing zero clears it, and a same-cycle event wins over the clear.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (cap_evt || cmp_evt)
      flag_q <= 1'b1; // [R5] [R14]
    else if (wr_lane0 && idx == CCU_IDX_FLAG)
      flag_q <= flag_q && avs_writedata[CCU_EVENT_BIT]; // [R5]
  end

  // Compare output latch, separate from the port data latch.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cmp_latch_q <= 1'b0;
    else if (wr_lane0 && idx == CCU_IDX_CTRL && avs_writedata[7:0] == 8'h00)
      cmp_latch_q <= 1'b0; // [R16]
    else if (cmp_evt && mode == CCU_MODE_CMP_HIGH)
      cmp_latch_q <= 1'b1; // [R13]
    else if (cmp_evt && mode == CCU_MODE_CMP_LOW)
      cmp_latch_q <= 1'b0; // [R13]
  end

  // Special event trigger: one-cycle clear of the timebase unless software writes it
  // in the same cycle, and a one-cycle conversion start. No overflow flag is raised here.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tb_clear_q  <= 1'b0;
      adc_start_q <= 1'b0;
    end
    else
    begin
      tb_clear_q  <= cmp_evt && (mode == CCU_MODE_CMP_SEV) && !tb_write; // [R18] [R20] [R21] [R22]
      adc_start_q <= cmp_evt && (mode == CCU_MODE_CMP_SEV); // [R19] [R20]
    end
  end

  // Pin driver: compare modes show the compare latch, otherwise the port latch passes.
  // The direction bit stays under software control, one means input.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end
    else
    begin
      pin_out_q <= ccu_is_compare(mode) ? cmp_latch_q : port_data; // [R13] [R17]
      pin_oe_q  <= !port_dir_in; // [R15]
    end
  end

  // Registered outputs.
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tb_clear        = tb_clear_q;
  assign adc_start       = adc_start_q;
  assign pin_out         = pin_out_q;
  assign pin_oe          = pin_oe_q;

  // Checks on the unit's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_bus_wait;
    (avs_read || avs_write) && wait_q;
  endsequence

  sequence s_bus_accept;
    !wait_q ##1 wait_q;
  endsequence

  property p_bus_handshake;
    s_bus_wait |=> s_bus_accept;
  endproperty
  a_bus_handshake: assert property (p_bus_handshake) else $error("bus handshake timing wrong"); // [R1]

  property p_capture_copy;
    cap_evt |=> ({val_hi_q, val_lo_q} == $past(tb_count)) && flag_q;
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture value or flag wrong"); // [R3]

  property p_flag_any;
    (cmp_evt || cap_evt) |=> flag_q;
  endproperty
  a_flag_any: assert property (p_flag_any) else $error("event did not set the flag"); // [R14]

  property p_off_quiet;
    (mode == CCU_MODE_OFF) |-> !cap_evt && !cmp_evt && (psc_q == 4'h0);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("unit acted while off"); // [R23]

  property p_psc_clear;
    !ccu_is_capture(mode) |=> (psc_q == 4'h0);
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared"); // [R10]

  property p_cmp_drive;
    cmp_evt && (mode == CCU_MODE_CMP_HIGH) && !wr_acc |=> cmp_latch_q ##1 pin_out_q;
  endproperty
  a_cmp_drive: assert property (p_cmp_drive) else $error("compare did not drive pin high"); // [R13]

  property p_swi_stable;
    cmp_evt && (mode == CCU_MODE_CMP_SWI) && !wr_acc |=> $stable(cmp_latch_q);
  endproperty
  a_swi_stable: assert property (p_swi_stable) else $error("software mode moved the latch"); // [R17]

  property p_zero_ctrl;
    wr_lane0 && (idx == CCU_IDX_CTRL) && (avs_writedata[7:0] == 8'h00) |=> !cmp_latch_q;
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl) else $error("zero control left latch high"); // [R16]

  sequence s_sev_pulse;
    tb_clear_q && adc_start_q ##1 !tb_clear_q && !adc_start_q;
  endsequence

  property p_sev;
    cmp_evt && (mode == CCU_MODE_CMP_SEV) && !tb_write |=> s_sev_pulse;
  endproperty
  a_sev: assert property (p_sev) else $error("special event pulse wrong"); // [R18]

  property p_write_wins;
    cmp_evt && (mode == CCU_MODE_CMP_SEV) && tb_write |=> !tb_clear_q && adc_start_q;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("timebase write lost to trigger"); // [R22]

endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the capture/compare unit over its register bus and pin.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccu_pkg::*;
  localparam logic [9:0] A_FLG = {CCU_IDX_FLAG, 2'b00};
  localparam logic [9:0] A_LO  = {CCU_IDX_VAL_LO, 2'b00};
  localparam logic [9:0] A_HI  = {CCU_IDX_VAL_HI, 2'b00};
  localparam logic [9:0] A_CTL = {CCU_IDX_CTRL, 2'b00};
  localparam logic [31:0] F1   = 32'h0000_0004;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] tb_count;
  logic        tb_write;
  logic        tb_clear;
  logic        adc_start;
  logic        port_dir_in = 1'b1;
  logic        port_data = 1'b0;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe;
  logic        run = 1'b0;
  logic        load_en = 1'b0;
  logic [15:0] load_val = '0;
  logic        src_lvl = 1'b0;
  int          err_total = 0;
  int          n_checks = 0;
  int          nclr;
  int          nadc;
  logic [3:0]  cmode [3] = '{CCU_MODE_CMP_LOW, CCU_MODE_CMP_HIGH, CCU_MODE_CMP_SWI};
  logic        cpin [3] = '{1'b0, 1'b1, 1'b1};

  // 10 MHz system clock.
  always #50 mclk = ~mclk;

  ccu_top DUT (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tb_count(tb_count),
    .tb_write(tb_write), .tb_clear(tb_clear), .adc_start(adc_start),
    .port_dir_in(port_dir_in), .port_data(port_data), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));

  ccu_pin_model u_far (.mclk(mclk), .rst(rst), .run(run), .load_en(load_en),
    .load_val(load_val), .src_lvl(src_lvl), .pin_oe(pin_oe), .pin_out(pin_out),
    .tb_clear(tb_clear), .tb_count(tb_count), .tb_write(tb_write), .pin_in(pin_in));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is sampled low, bounded by a count.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64)
      chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(name, exp, q);
  endtask

  // The synchroniser needs a few cycles, so each pin step is given eight.
  task automatic lvl(input logic v);
    src_lvl <= v;
    repeat (8) @(posedge mclk);
  endtask

  task automatic rises(input int n);
    repeat (n)
    begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask

  task automatic tbload(input logic [15:0] v, input int n);
    load_val <= v;
    load_en  <= 1'b1;
    repeat (n) @(posedge mclk);
    load_en  <= 1'b0;
    @(posedge mclk);
  endtask

  // Counts trigger and conversion pulses over a span of cycles.
  task automatic pulses(input int n);
    nclr = 0;
    nadc = 0;
    repeat (n)
    begin
      @(posedge mclk);
      nclr += (tb_clear === 1'b1);
      nadc += (adc_start === 1'b1);
    end
  endtask

  // Stops a hung run well after the tests should have finished.
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rc("value low", A_LO, 32'h0000_0000);
    rc("value high", A_HI, 32'h0000_0000);
    rc("control", A_CTL, {24'h00_0000, CCU_CTRL_RESET});
    wr(A_LO, 8'hA5);
    wr(A_HI, 8'h5A);
    wr(A_CTL, 8'hFF);
    rc("value low", A_LO, 32'h0000_00A5);
    rc("value high", A_HI, 32'h0000_005A);
    rc("control", A_CTL, 32'h0000_003F);
    rc("unmapped", 10'h3FC, 32'h0000_0000);
    rc("flag reset", A_FLG, 32'h0000_0000);
    wr({CCU_IDX_ENABLE, 2'b00}, 8'h04);
    rc("enable", {CCU_IDX_ENABLE, 2'b00}, F1);
    wr(A_CTL, 8'h00);
    wr(A_FLG, 8'h00);
    // Rising-edge capture, then the already read value overwritten by a second capture before the flag is cleared.
    tbload(16'h1234, 1);
    wr(A_CTL, {4'h0, CCU_MODE_CAP_RISE});
    rises(1);
    rc("flag", A_FLG, F1);
    rc("cap low", A_LO, 32'h0000_0034);
    rc("cap high", A_HI, 32'h0000_0012);
    tbload(16'h5678, 1);
    rises(1);
    rc("cap low", A_LO, 32'h0000_0078);
    rc("cap high", A_HI, 32'h0000_0056);
    wr(A_FLG, 8'h00);
    rc("flag clr", A_FLG, 32'h0000_0000);
    // Falling-edge capture ignores the rising edge.
    wr(A_CTL, {4'h0, CCU_MODE_CAP_FALL});
    tbload(16'h0111, 1);
    lvl(1'b1);
    rc("fall rise", A_FLG, 32'h0000_0000);
    lvl(1'b0);
    rc("fall flag", A_FLG, F1);
    rc("fall low", A_LO, 32'h0000_0011);
    // Prescaled modes after a clean off; the enable is cleared around mode changes.
    for (int m = 0; m < 2; m++)
    begin
      wr(A_CTL, 8'h00);
      wr({CCU_IDX_ENABLE, 2'b00}, 8'h00);
      wr(A_CTL, (m == 0) ? {4'h0, CCU_MODE_CAP_4TH} : {4'h0, CCU_MODE_CAP_16TH});
      wr(A_FLG, 8'h00);
      rises((m == 0) ? 3 : 15);
      rc("psc early", A_FLG, 32'h0000_0000);
      rises(1);
      rc("psc fire", A_FLG, F1);
    end
    // A direct switch keeps the prescaler count.
    wr(A_CTL, 8'h00);
    wr(A_CTL, {4'h0, CCU_MODE_CAP_4TH});
    rises(2);
    wr(A_CTL, {4'h0, CCU_MODE_CAP_16TH});
    wr(A_FLG, 8'h00);
    rises(13);
    rc("switch early", A_FLG, 32'h0000_0000);
    rises(1);
    rc("switch fire", A_FLG, F1);
    wr(A_CTL, 8'h00);
    wr(A_FLG, 8'h00);
    rises(1);
    rc("off flag", A_FLG, 32'h0000_0000);
    // Pin driven by the port latch in capture mode.
    port_dir_in <= 1'b0;
    wr(A_CTL, {4'h0, CCU_MODE_CAP_RISE});
    port_data <= 1'b1;
    repeat (8) @(posedge mclk);
    rc("port capture", A_FLG, F1);
    port_data <= 1'b0;
    // Compare sub-modes: set low, set high, then software only keeps the pin.
    for (int i = 0; i < 3; i++)
    begin
      tbload(16'h0000, 1);
      wr(A_LO, 8'h40);
      wr(A_HI, 8'h00);
      wr(A_CTL, {4'h0, cmode[i]});
      wr(A_FLG, 8'h00);
      tbload(16'h0030, 1);
      run <= 1'b1;
      repeat (30) @(posedge mclk);
      run <= 1'b0;
      rc("cmp flag", A_FLG, F1);
      chk("pin out", {31'h0, cpin[i]}, {31'h0, pin_out});
      chk("pin oe", 32'h0000_0001, {31'h0, pin_oe});
    end
    wr(A_CTL, 8'h00);
    wr(A_CTL, {4'h0, CCU_MODE_CMP_SWI});
    repeat (3) @(posedge mclk);
    chk("latch zero", 32'h0000_0000, {31'h0, pin_out});
    // Special event trigger, then a coinciding timebase write.
    wr(A_CTL, 8'h00);
    wr(A_LO, 8'h50);
    wr(A_CTL, {4'h0, CCU_MODE_CMP_SEV});
    tbload(16'h0048, 1);
    run <= 1'b1;
    pulses(20);
    run <= 1'b0;
    chk("clear pulses", 32'd1, nclr);
    chk("adc pulses", 32'd1, nadc);
    chk("count", 32'd1, {31'h0, tb_count < 16'h0014});
    tbload(16'h0000, 1);
    fork
      tbload(16'h0050, 3);
      pulses(10);
    join
    chk("clear w write", 32'd0, nclr);
    chk("adc w write", 32'd1, nadc);
    summarize();
  end
endmodule
`default_nettype wire
